//--- hw/shs_exec.sv
// decode and execute of float-single and halfword stores
// What this block does
// - opcode 31 xo 695: float store update indexed
// - float stores write single as word, rounded only inside single range
// - indexed address is base plus index, or index
// - float update writes base only if fault-free
// - float stores touch no status or condition
// - opcode 31 xo 663 is float store indexed
// - opcode 44 is halfword store with displacement
// - halfword stores write source bits 16-31
// - displacement address is base plus signed offset, or offset
// - halfword stores touch no status or condition
// - opcode 31 xo 918 is byte-reversed indexed
// - byte-reversed store swaps the two bytes
// - opcode 45 is halfword store with update
// - halfword update writes base only if fault-free
// - opcode 31 xo 439 is halfword update indexed
`timescale 1ns/1ps
`include "shs_params.svh"

module shs_exec (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // instruction issue
    input  wire logic        instr_valid,
    output logic             instr_ready,
    input  wire logic [31:0] instr,
    // register file read ports
    output logic [4:0]       base_reg,
    output logic [4:0]       index_reg,
    output logic [4:0]       int_source_reg,
    output logic [4:0]       float_source_reg,
    input  wire logic [31:0] base_val,
    input  wire logic [31:0] index_val,
    input  wire logic [31:0] int_source_val,
    input  wire logic [63:0] float_source_val,
    // data memory port
    output logic             mem_valid,
    input  wire logic        mem_ack,
    input  wire logic        mem_fault,
    output logic [31:0]      target_addr,
    output logic [31:0]      mem_wdata,
    output logic             mem_word,
    // base register write back
    output logic             wb_valid,
    output logic [4:0]       wb_idx,
    output logic [31:0]      wb_data,
    // completion
    output logic             done,
    output logic             fault,
    output logic             unsupported
);

    // instruction classes
    typedef enum logic [2:0] {
        SHS_K_NONE,
        SHS_K_STFSX,
        SHS_K_STFSUX,
        SHS_K_STH,
        SHS_K_STHU,
        SHS_K_STHBRX,
        SHS_K_STHUX
    } shs_kind_t;

    // primary opcode, big-endian bits 0-5
    function automatic logic [5:0] shs_opcd_field(input logic [31:0] iw);
        return iw[`SHS_F_OPCD_HI:`SHS_F_OPCD_LO];
    endfunction : shs_opcd_field

    // extended opcode, big-endian bits 21-30
    function automatic logic [9:0] shs_xo_field(input logic [31:0] iw);
        return iw[`SHS_F_XO_HI:`SHS_F_XO_LO];
    endfunction : shs_xo_field

    // data source register number, int or float
    function automatic logic [4:0] shs_src_field(input logic [31:0] iw);
        return iw[`SHS_F_SRC_HI:`SHS_F_SRC_LO];
    endfunction : shs_src_field

    // base register number, also the update target
    function automatic logic [4:0] shs_base_field(input logic [31:0] iw);
        return iw[`SHS_F_BASE_HI:`SHS_F_BASE_LO];
    endfunction : shs_base_field

    // index register number of the indexed forms
    function automatic logic [4:0] shs_index_field(input logic [31:0] iw);
        return iw[`SHS_F_INDEX_HI:`SHS_F_INDEX_LO];
    endfunction : shs_index_field

    // displacement sign-extended to a full address
    function automatic logic [31:0] shs_disp_ext(input logic [31:0] iw);
        return {{16{iw[`SHS_F_DISP_HI]}}, iw[`SHS_F_DISP_HI:`SHS_F_DISP_LO]};
    endfunction : shs_disp_ext

    // classify an instruction word
    function automatic shs_kind_t shs_decode(input logic [31:0] iw);
        shs_kind_t k;
        k = SHS_K_NONE;
        case (shs_opcd_field(iw))
            `SHS_OP_STH:  k = SHS_K_STH;
            `SHS_OP_STHU: k = SHS_K_STHU;
            `SHS_OP_X: begin
                case (shs_xo_field(iw))
                    `SHS_XO_STFSUX: k = SHS_K_STFSUX;
                    `SHS_XO_STFSX:  k = SHS_K_STFSX;
                    `SHS_XO_STHBRX: k = SHS_K_STHBRX;
                    `SHS_XO_STHUX:  k = SHS_K_STHUX;
                    default:        k = SHS_K_NONE;
                endcase
            end
            default: k = SHS_K_NONE;
        endcase
        return k;
    endfunction : shs_decode

    // double to single, round to nearest even
    function automatic logic [31:0] shs_to_single(input logic [63:0] d);
        logic        s;
        logic [10:0] e;
        logic [51:0] m;
        logic [12:0] ex;
        logic        rnd;
        logic [31:0] r;
        s   = d[63];
        e   = d[62:52];
        m   = d[51:0];
        ex  = {2'h0, e} - `SHS_EXP_REBIAS;
        // round up past half, or on a tie with an odd lsb
        rnd = m[28] & ((|m[27:0]) | m[29]);
        r   = {s, 31'h0};
        if (e == 11'h7FF) begin
            // infinity, or nan kept non-zero
            r = {s, 8'hFF, m[51:29] | {22'h0, |m[28:0]}};
        end else if (ex[12] || ex == 13'h0000) begin
            // too small: flush to signed zero
            r = {s, 31'h0};
        end else if (ex >= `SHS_EXP_MAX) begin
            // beyond single range: sign, exponent top bit and low
            // exponent bits pass with the leading mantissa, unrounded,
            // so a huge double is stored bit-selected, not saturated
            r = {d[63:62], d[58:29]};
        end else begin
            // carry out of mantissa bumps exponent
            r = {s, ex[7:0], m[51:29]} + {31'h0, rnd};
        end
        return r;
    endfunction : shs_to_single

    // decoded fields, big-endian bit 0 is msb
    shs_kind_t   kind;            // current instruction class
    logic        base_nz;         // base field non-zero
    logic [31:0] disp_ext;        // sign-extended displacement
    logic [31:0] addr_idx;        // indexed address
    logic [31:0] addr_disp;       // displacement address

    shs_pkg::shs_regs_t r;        // state
    shs_pkg::shs_regs_t next_r;   // next state

    // field extraction for register reads
    // numbers go straight out, so read data returns in the issue cycle
    always_comb begin
        float_source_reg = shs_src_field(instr);
        int_source_reg   = shs_src_field(instr);
        base_reg         = shs_base_field(instr);
        index_reg        = shs_index_field(instr);
    end

    // address formation
    // both sums are formed every cycle and the class picks one;
    // a carry out of the top bit is dropped, so addresses wrap around
    always_comb begin
        kind     = shs_decode(instr);
        base_nz  = (shs_base_field(instr) != 5'h00);
        disp_ext = shs_disp_ext(instr);
        // index alone when base field is zero
        addr_idx = base_nz ? base_val + index_val : index_val;
        // offset alone when base field is zero
        addr_disp = base_nz ? base_val + disp_ext : disp_ext;
    end

    // next state
    // only one store is in flight: a word is taken only in idle, and
    // every value it needs is captured then, so the register file may
    // move on while the memory port waits
    always_comb begin
        next_r       = r;
        // pulses last one cycle
        next_r.wb_v  = 1'b0;
        next_r.done  = 1'b0;
        next_r.fault = 1'b0;
        next_r.bad   = 1'b0;
        case (r.st)
            shs_pkg::SHS_IDLE: begin
                if (instr_valid) begin
                    // base number kept for the later write back
                    next_r.base = shs_base_field(instr);
                    case (kind)
                        SHS_K_STFSX, SHS_K_STFSUX: begin
                            // word of rounded single
                            next_r.st   = shs_pkg::SHS_MEM;
                            next_r.addr = addr_idx;
                            next_r.data = shs_to_single(float_source_val);
                            next_r.word = 1'b1;
                            next_r.upd  = (kind == SHS_K_STFSUX) && base_nz;
                        end
                        SHS_K_STH, SHS_K_STHU: begin
                            // low halfword, displacement form
                            next_r.st   = shs_pkg::SHS_MEM;
                            next_r.addr = addr_disp;
                            next_r.data = {16'h0000, int_source_val[15:0]};
                            next_r.word = 1'b0;
                            next_r.upd  = (kind == SHS_K_STHU) && base_nz;
                        end
                        SHS_K_STHBRX: begin
                            // bytes swapped, indexed form
                            next_r.st   = shs_pkg::SHS_MEM;
                            next_r.addr = addr_idx;
                            next_r.data = {16'h0000, int_source_val[7:0],
                                           int_source_val[15:8]};
                            next_r.word = 1'b0;
                            next_r.upd  = 1'b0;
                        end
                        SHS_K_STHUX: begin
                            // low halfword, indexed with update
                            next_r.st   = shs_pkg::SHS_MEM;
                            next_r.addr = addr_idx;
                            next_r.data = {16'h0000, int_source_val[15:0]};
                            next_r.word = 1'b0;
                            next_r.upd  = base_nz;
                        end
                        default: begin
                            // not one of ours: refuse with a flag
                            next_r.bad = 1'b1;
                        end
                    endcase
                end
            end
            shs_pkg::SHS_MEM: begin
                // a suppressed access still completes, with fault set
                if (mem_ack) begin
                    next_r.st    = shs_pkg::SHS_IDLE;
                    next_r.done  = 1'b1;
                    next_r.fault = mem_fault;
                    // update only a fault-free access, never status
                    if (r.upd && !mem_fault) begin
                        next_r.wb_v    = 1'b1;
                        next_r.wb_idx  = r.base;
                        next_r.wb_data = r.addr;
                    end
                end
            end
            default: begin
                next_r.st = shs_pkg::SHS_IDLE;
            end
        endcase
    end

    // state register
    // sync reset: idle, no pulses, data outputs cleared
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r.st      <= shs_pkg::SHS_IDLE;
            r.addr    <= `SHS_ADDR_RST;
            r.data    <= `SHS_DATA_RST;
            r.word    <= 1'b0;
            r.upd     <= 1'b0;
            r.base    <= 5'h00;
            r.wb_v    <= 1'b0;
            r.wb_idx  <= 5'h00;
            r.wb_data <= `SHS_DATA_RST;
            r.done    <= 1'b0;
            r.fault   <= 1'b0;
            r.bad     <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // memory request: all fields held together
    // r changes only in idle and at the ack edge, so address, data and
    // size stand unchanged for as long as the request is pending
    always_comb begin
        instr_ready = (r.st == shs_pkg::SHS_IDLE);
        mem_valid   = (r.st == shs_pkg::SHS_MEM);
        target_addr = r.addr;
        mem_wdata   = r.data;
        mem_word    = r.word;
    end

    // result outputs
    // done, fault, write back and refusal each last one cycle;
    // the write back number and address stay until the next one
    always_comb begin
        wb_valid    = r.wb_v;
        wb_idx      = r.wb_idx;
        wb_data     = r.wb_data;
        done        = r.done;
        fault       = r.fault;
        unsupported = r.bad;
    end

endmodule : shs_exec

//--- hw/shs_params.svh
// constants for the store half / single execute unit
`ifndef SHS_PARAMS_SVH
`define SHS_PARAMS_SVH
`define SHS_OP_X        6'h1F
`define SHS_OP_STH      6'h2C
`define SHS_OP_STHU     6'h2D
`define SHS_XO_STFSX    10'h297
`define SHS_XO_STFSUX   10'h2B7
`define SHS_XO_STHBRX   10'h396
`define SHS_XO_STHUX    10'h1B7
`define SHS_EXP_REBIAS  13'h0380
`define SHS_EXP_MAX     13'h00FF
`define SHS_ADDR_RST    32'h0000_0000
`define SHS_DATA_RST    32'h0000_0000
`define SHS_F_OPCD_HI   31
`define SHS_F_OPCD_LO   26
`define SHS_F_XO_HI     10
`define SHS_F_XO_LO     1
`define SHS_F_SRC_HI    25
`define SHS_F_SRC_LO    21
`define SHS_F_BASE_HI   20
`define SHS_F_BASE_LO   16
`define SHS_F_INDEX_HI  15
`define SHS_F_INDEX_LO  11
`define SHS_F_DISP_HI   15
`define SHS_F_DISP_LO   0
`endif

//--- hw/shs_pkg.sv
// types for the store half / single execute unit
package shs_pkg;
    typedef enum logic {
        SHS_IDLE,
        SHS_MEM
    } shs_state_t;

    typedef struct packed {
        shs_state_t  st;
        logic [31:0] addr;
        logic [31:0] data;
        logic        word;
        logic        upd;
        logic [4:0]  base;
        logic        wb_v;
        logic [4:0]  wb_idx;
        logic [31:0] wb_data;
        logic        done;
        logic        fault;
        logic        bad;
    } shs_regs_t;
endpackage : shs_pkg

//--- testbench/shs_exec_sva.sv
// concurrent checks on the store half / single execute unit ports
`timescale 1ns/1ps
module shs_exec_sva (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        instr_valid,
    input wire logic        instr_ready,
    input wire logic [31:0] instr,
    input wire logic        mem_valid,
    input wire logic        mem_ack,
    input wire logic        mem_fault,
    input wire logic [31:0] target_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_word,
    input wire logic        wb_valid,
    input wire logic [4:0]  wb_idx,
    input wire logic [31:0] wb_data,
    input wire logic        done,
    input wire logic        fault,
    input wire logic        unsupported
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // opcode fields of the offered word
    wire logic [5:0] op = instr[31:26];
    wire logic [9:0] xo = instr[10:1];
    wire logic       fp = (op == 6'h1F) && (xo == 10'h297 || xo == 10'h2B7);
    wire logic       known = fp || op == 6'h2C || op == 6'h2D
                          || (op == 6'h1F && (xo == 10'h396 || xo == 10'h1B7));
    // accepted issue and accepted memory access
    sequence issue_s; instr_valid && instr_ready; endsequence
    sequence acc_end_s; mem_valid && mem_ack; endsequence

    issue_access_a: assert property (issue_s ##0 known |=> mem_valid && !unsupported)
        else $error("known store did not start an access");
    unknown_op_a: assert property (issue_s ##0 !known |=> unsupported && !mem_valid)
        else $error("unknown opcode not refused");
    req_hold_a: assert property (mem_valid && !mem_ack |=> mem_valid
        && $stable({target_addr, mem_wdata, mem_word}))
        else $error("request changed before ack");
    ack_done_a: assert property (acc_end_s |=> done && !mem_valid && fault == $past(mem_fault))
        else $error("completion does not follow ack");
    busy_ready_a: assert property (mem_valid |-> !instr_ready)
        else $error("ready while access pending");
    wb_ok_a: assert property (wb_valid |-> done && !fault && wb_idx != 5'h00
        && wb_data == $past(target_addr))
        else $error("bad base write back");
    size_sel_a: assert property (issue_s ##0 known |=> mem_word == $past(fp))
        else $error("wrong access size");
    half_upper_a: assert property (mem_valid && !mem_word |-> mem_wdata[31:16] == 16'h0000)
        else $error("halfword data upper bits set");
endmodule : shs_exec_sva

bind shs_exec shs_exec_sva u_sva (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .mem_valid(mem_valid), .mem_ack(mem_ack),
    .mem_fault(mem_fault), .target_addr(target_addr), .mem_wdata(mem_wdata),
    .mem_word(mem_word), .wb_valid(wb_valid), .wb_idx(wb_idx), .wb_data(wb_data),
    .done(done), .fault(fault), .unsupported(unsupported));

//--- testbench/shs_mem_model.sv
// data memory port model with programmable wait and fault
`timescale 1ns/1ps
module shs_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        mem_valid,
    input  wire logic [31:0] target_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic        mem_word,
    input  wire logic [3:0]  wait_cyc,
    input  wire logic        fault_en,
    output logic             mem_ack = 1'b0,
    output logic             mem_fault = 1'b0,
    output logic [31:0]      wr_addr = 32'h0000_0000,
    output logic [31:0]      wr_data = 32'h0000_0000,
    output logic             wr_word = 1'b0,
    output int               wr_count = 0
);
    logic [3:0] cnt = 4'h0; // cycles the request has waited
    // one-cycle ack after the wait; fault line toggles outside an ack
    always @(posedge clk_sys) begin
        mem_ack <= 1'b0;
        mem_fault <= ~mem_fault;
        if (mem_valid && !mem_ack) begin
            if (cnt == wait_cyc) begin
                mem_ack <= 1'b1;
                mem_fault <= fault_en;
                cnt <= 4'h0;
                if (!fault_en) begin
                    wr_addr <= target_addr;
                    wr_data <= mem_wdata;
                    wr_word <= mem_word;
                    wr_count <= wr_count + 1;
                end
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : shs_mem_model

//--- testbench/tb_store_half_single_exec.sv
// self-checking bench for the store half / single execute unit
`timescale 1ns/1ps
module tb_store_half_single_exec;
    logic clk_sys = 1'b0, rst = 1'b1, instr_valid = 1'b0, fault_en = 1'b0;
    logic [31:0] instr = 32'h0, base_val = 32'h0, index_val = 32'h0, int_source_val = 32'h0;
    logic [63:0] float_source_val = 64'h0;
    logic [3:0]  wait_cyc = 4'h0;
    logic instr_ready, mem_valid, mem_ack, mem_fault, mem_word, wb_valid, done, fault;
    logic unsupported, wr_word;
    logic [31:0] target_addr, mem_wdata, wb_data, wr_addr, wr_data;
    logic [4:0]  wb_idx, base_reg, index_reg, int_source_reg, float_source_reg;
    int err_count = 0, checks = 0, wr_count;

    shs_exec uut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr(instr), .base_reg(base_reg), .index_reg(index_reg),
        .int_source_reg(int_source_reg), .float_source_reg(float_source_reg),
        .base_val(base_val), .index_val(index_val),
        .int_source_val(int_source_val), .float_source_val(float_source_val),
        .mem_valid(mem_valid), .mem_ack(mem_ack), .mem_fault(mem_fault),
        .target_addr(target_addr), .mem_wdata(mem_wdata), .mem_word(mem_word),
        .wb_valid(wb_valid), .wb_idx(wb_idx), .wb_data(wb_data), .done(done),
        .fault(fault), .unsupported(unsupported));
    shs_mem_model mem (.clk_sys(clk_sys), .mem_valid(mem_valid), .target_addr(target_addr),
        .mem_wdata(mem_wdata), .mem_word(mem_word), .wait_cyc(wait_cyc), .fault_en(fault_en),
        .mem_ack(mem_ack), .mem_fault(mem_fault), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_word(wr_word), .wr_count(wr_count));

    always #50 clk_sys = ~clk_sys;

    task automatic tally_and_finish;
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    // indexed and displacement instruction words
    function automatic logic [31:0] xf(input logic [9:0] xo, input logic [4:0] a, b);
        return {6'h1F, 5'h06, a, b, xo, 1'b0};
    endfunction : xf
    function automatic logic [31:0] df(input logic [5:0] op, input logic [4:0] a,
                                       input logic [15:0] d);
        return {op, 5'h06, a, d};
    endfunction : df

    // issue one store, wait for completion, judge request and write back
    task automatic run_op(input logic [31:0] ins, bv, iv, sv, input logic [3:0] w,
                          input logic f, input logic [31:0] exp_addr, wd, input logic wrd, upd);
        int n;
        int c0;
        c0 = wr_count;
        @(negedge clk_sys);
        instr = ins;
        base_val = bv;
        index_val = iv;
        int_source_val = sv;
        wait_cyc = w;
        fault_en = f;
        instr_valid = 1'b1;
        @(negedge clk_sys);
        instr_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk(base_reg === ins[20:16] && index_reg === ins[15:11], "base or index field");
        chk(int_source_reg === ins[25:21], "int source field");
        chk(float_source_reg === ins[25:21], "float source field");
        chk(done === 1'b1 && fault === f, "completion or fault flag");
        chk(wr_count == c0 + (f ? 0 : 1), "memory write count");
        if (!f) chk(wr_addr === exp_addr && wr_data === wd && wr_word === wrd, "store");
        chk(wb_valid === upd, "write back strobe");
        if (upd) chk(wb_data === exp_addr && wb_idx === ins[20:16], "write back");
    endtask : run_op

    task automatic s_float;
        float_source_val = 64'h4865_6C6C_6F20_776F;
        run_op(xf(10'h2B7, 5'h05, 5'h04), 32'h0000_1000, 32'h0000_0008, 32'h0, 4'h0, 1'b0,
               32'h0000_1008, 32'h432B_6363, 1'b1, 1'b1);
        run_op(xf(10'h2B7, 5'h05, 5'h04), 32'h0000_1000, 32'h0000_0008, 32'h0, 4'h2, 1'b1,
               32'h0, 32'h0, 1'b1, 1'b0);
        run_op(xf(10'h297, 5'h00, 5'h04), 32'hDEAD_BEEF, 32'h0000_2000, 32'h0, 4'h3, 1'b0,
               32'h0000_2000, 32'h432B_6363, 1'b1, 1'b0);
    endtask : s_float

    task automatic s_half;
        run_op(df(6'h2C, 5'h04, 16'hFFFC), 32'h0000_0100, 32'h0, 32'h9000_3000, 4'h1, 1'b0,
               32'h0000_00FC, 32'h0000_3000, 1'b0, 1'b0);
        run_op(df(6'h2D, 5'h00, 16'h8000), 32'h5555_5555, 32'h0, 32'h9000_3456, 4'h0, 1'b0,
               32'hFFFF_8000, 32'h0000_3456, 1'b0, 1'b0);
        run_op(df(6'h2D, 5'h04, 16'h0010), 32'h0000_0100, 32'h0, 32'h9000_3456, 4'h0, 1'b0,
               32'h0000_0110, 32'h0000_3456, 1'b0, 1'b1);
        run_op(xf(10'h396, 5'h00, 5'h04), 32'h0, 32'h0000_0040, 32'h9000_3456, 4'h0, 1'b0,
               32'h0000_0040, 32'h0000_5634, 1'b0, 1'b0);
        run_op(xf(10'h1B7, 5'h04, 5'h05), 32'h0000_0007, 32'h0000_1000, 32'h9000_3456, 4'h1,
               1'b0, 32'h0000_1007, 32'h0000_3456, 1'b0, 1'b1);
        run_op(xf(10'h1B7, 5'h04, 5'h05), 32'h0000_0007, 32'h0000_1000, 32'h9000_3456, 4'h0,
               1'b1, 32'h0, 32'h0, 1'b0, 1'b0);
    endtask : s_half

    task automatic s_unknown;
        @(negedge clk_sys);
        instr = xf(10'h3B7, 5'h05, 5'h04);
        instr_valid = 1'b1;
        @(negedge clk_sys);
        instr_valid = 1'b0;
        chk(unsupported === 1'b1 && mem_valid === 1'b0, "unknown opcode accepted");
    endtask : s_unknown

    initial begin
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        s_float();
        s_half();
        s_unknown();
        tally_and_finish();
    end

    // watchdog cuts a hang short
    initial begin
        repeat (2000) @(posedge clk_sys);
        err_count++;
        tally_and_finish();
    end
endmodule : tb_store_half_single_exec
